/* hw/mipc_map.svh */
// Purpose: offsets, field positions, reset values and codes of the
//          maskable interrupt controller
// Assumes: register port with an 8-bit address and 32-bit data
// Notes: definitions only
`ifndef MIPC_MAP_SVH
`define MIPC_MAP_SVH

`define MIPC_NSRC 33
`define MIPC_CTL_BASE 8'h00
`define MIPC_BIT_BASE 8'h40
`define MIPC_PSW_ADDR 8'h80
`define MIPC_SPC_ADDR 8'h84
`define MIPC_SST_ADDR 8'h88
`define MIPC_ECR_ADDR 8'h8C
`define MIPC_IST_ADDR 8'h90
`define MIPC_ICLR_ADDR 8'h94
`define MIPC_IEN_ADDR 8'h98
`define MIPC_CFG_ADDR 8'h9C
`define MIPC_ISR_ADDR 8'hA0

`define MIPC_CTL_RESET 8'h47
`define MIPC_PSW_RESET 32'h00000020
`define MIPC_NP_BIT 7
`define MIPC_EP_BIT 6
`define MIPC_ID_BIT 5
`define MIPC_IF_BIT 7
`define MIPC_MK_BIT 6
`define MIPC_PR_MSB 2

`define MIPC_CODE_BASE 16'h0080
`define MIPC_NMI_CODE 16'h0010
`define MIPC_NMI_HANDLER 32'h00000010
`define MIPC_LVL_NONE 4'h8
`define MIPC_WDT_SRC 0
`define MIPC_NEV 3

`endif

/* hw/mipc_pkg.sv */
// Purpose: types shared by the interrupt controller modules
// Assumes: nothing
// Notes: field layout of one source control byte and the core carriers
package mipc_pkg;

    typedef struct packed {
        logic flag;
        logic mask;
        logic [2:0] pri;
    } mipc_ctl_type;

    typedef struct packed {
        logic [31:0] pc;
        logic return_from_irq;
        logic ei;
        logic di;
    } mipc_core_type;

    typedef struct packed {
        logic valid;
        logic nmi;
        logic [31:0] pc;
    } mipc_vec_type;

endpackage

/* hw/mipc_srcreg.sv */
// Purpose: one per-source control byte: pending flag, mask, priority
// Assumes: byte and single-bit writes never come in the same cycle
// Notes: bits 5..3 of the byte are not stored and read as zero
`timescale 1ns/100ps
`include "mipc_map.svh"
module mipc_srcreg
    import mipc_pkg::*;
(
    input wire logic mclk, // Clock
    input wire logic rst_n, // Synchronous reset
    input wire logic req, // Request pulse from the source
    input wire logic take, // Request acknowledged
    input wire logic wr_byte, // Whole-byte write
    input wire logic wr_bit, // Single-bit write
    input wire logic [2:0] bit_sel, // Bit position for bit write
    input wire logic bit_val, // Value for bit write
    input wire logic [7:0] wdata, // Byte write data
    output mipc_ctl_type ctl // Stored control fields
);

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            ctl.flag <= 1'(`MIPC_CTL_RESET >> `MIPC_IF_BIT);
            ctl.mask <= 1'((`MIPC_CTL_RESET >> `MIPC_MK_BIT) & 8'h01);
            ctl.pri <= 3'(`MIPC_CTL_RESET & 8'h07);
        end else begin
            // A new request beats any clear in the same cycle
            if (req) begin
                ctl.flag <= 1'b1;
            end else if (take) begin
                ctl.flag <= 1'b0;
            end else if (wr_byte) begin
                ctl.flag <= wdata[`MIPC_IF_BIT];
            end else if (wr_bit && bit_sel == 3'h7) begin
                ctl.flag <= bit_val;
            end
            if (wr_byte) begin
                ctl.mask <= wdata[`MIPC_MK_BIT];
                ctl.pri <= wdata[`MIPC_PR_MSB:0];
            end else if (wr_bit) begin
                if (bit_sel == 3'h6) begin
                    ctl.mask <= bit_val;
                end
                if (bit_sel <= 3'h2) begin
                    ctl.pri[bit_sel[1:0]] <= bit_val;
                end
            end
        end
    end

    req_sets_flag_a: assert property (@(posedge mclk) disable iff (!rst_n)
        req |=> ctl.flag)
        else $error("request did not set pending flag");

endmodule

/* hw/mipc_arbiter.sv */
// Purpose: pick the pending unmasked source with the best level
// Assumes: level 0 is the most urgent, index 0 the first by default
// Notes: purely combinational
`timescale 1ns/100ps
`include "mipc_map.svh"
module mipc_arbiter
    import mipc_pkg::*;
(
    input mipc_ctl_type ctl [`MIPC_NSRC], // Control fields of all sources
    output logic valid, // Some source is eligible
    output logic [5:0] idx, // Winning source
    output logic [2:0] lvl // Level of the winner
);

    always_comb begin
        valid = 1'b0;
        idx = 6'h00;
        lvl = 3'h7;
        // Walk downward so a lower index wins a tie of levels
        for (int i = `MIPC_NSRC - 1; i >= 0; i--) begin
            if (ctl[i].flag && !ctl[i].mask
                && (!valid || ctl[i].pri <= lvl)) begin
                valid = 1'b1;
                idx = 6'(i);
                lvl = ctl[i].pri;
            end
        end
    end

endmodule

/* hw/mipc_irq_ctrl.sv */
// Purpose: maskable interrupt priority, nesting and status word logic
// Assumes: the core reports return-from-irq and the enable/disable
//          instructions as one-cycle pulses beside its current PC
// Notes: vector outputs are registered, one cycle after the decision
//
// What this block does
// - Acknowledging a non-maskable request sets status bit 7, which then holds off further ones.
// - That bit reads 0 with no non-maskable service running and 1 while one runs.
// - There are 33 maskable sources, each masked by its own control register.
// - Each source has one of eight levels; the best level wins and default order breaks ties.
// - Acknowledging a maskable request sets the disable flag, blocking others until cleared.
// - With interrupts re-enabled in a handler only strictly better levels may nest.
// - With the watchdog select bit at 0 the watchdog overflow is an ordinary maskable source.
// - Acknowledge saves PC, saves status, writes the cause code, disables, clears EP, jumps.
// - A request stays pending while masked or while the NMI or disable flag is set.
// - Return with EP and NP at 0 reloads PC and status word from the saved registers.
// - Each source has an 8-bit control register writable as a byte or one bit.
// - Every source control register resets to 47H.
// - The 3-bit priority field codes level 0 as highest up to level 7 as lowest.
// - The pending flag reads 1 from a request of its source until that request is acknowledged, else 0.
`timescale 1ns/100ps
`include "mipc_map.svh"
module mipc_irq_ctrl
    import mipc_pkg::*;
(
    input wire logic mclk, // 10 MHz clock
    input wire logic rst_n, // Synchronous reset, active low
    input wire logic [7:0] reg_addr, // Register address
    input wire logic [31:0] reg_wdata, // Register write data
    input wire logic reg_wr, // Write strobe
    input wire logic reg_rd, // Read strobe
    output logic [31:0] reg_rdata, // Read data, cycle after strobe
    input wire logic [`MIPC_NSRC-1:0] src_req, // Source request pulses
    input wire logic nmi_req, // Non-maskable request pulse
    input mipc_core_type core_in, // Core PC and instruction events
    output mipc_vec_type vec, // Jump request to the core
    output logic [31:0] status_word, // Current status word
    output logic irq // Level, enabled event pending
);

    mipc_ctl_type ctl [`MIPC_NSRC];
    logic [31:0] irq_saved_pc;
    logic [31:0] irq_saved_status;
    logic [31:0] exception_cause_reg;
    logic [31:0] nmi_saved_pc;
    logic [31:0] nmi_saved_status;
    logic [7:0] in_service;
    logic [`MIPC_NEV-1:0] ev_status;
    logic [`MIPC_NEV-1:0] ev_enable;
    logic watchdog_nmi_select;
    logic nmi_held;
    logic arb_valid;
    logic [5:0] arb_idx;
    logic [2:0] arb_lvl;
    logic [3:0] isr_top;
    logic [`MIPC_NSRC-1:0] eff_req;
    logic nmi_in;
    logic nmi_take;
    logic take;
    logic return_from_irq_m;
    logic return_from_irq_n;
    logic np_flag;
    logic ep_flag;
    logic id_flag;
    logic [`MIPC_NEV-1:0] ev_set;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] b,
                                 input int i);
        hit = a == b + 8'(i);
    endfunction

    function automatic logic [15:0] cause_of(input logic [5:0] i);
        cause_of = `MIPC_CODE_BASE + {6'h00, i, 4'h0};
    endfunction

    assign np_flag = status_word[`MIPC_NP_BIT];
    assign ep_flag = status_word[`MIPC_EP_BIT];
    assign id_flag = status_word[`MIPC_ID_BIT];

    // Watchdog overflow goes to the maskable side only when not selected
    always_comb begin
        eff_req = src_req;
        eff_req[`MIPC_WDT_SRC] = src_req[`MIPC_WDT_SRC]
            && !watchdog_nmi_select;
    end
    assign nmi_in = nmi_req
        || (src_req[`MIPC_WDT_SRC] && watchdog_nmi_select);

    generate
        for (genvar g = 0; g < `MIPC_NSRC; g++) begin : g_src
            mipc_srcreg u_src (
                .mclk(mclk),
                .rst_n(rst_n),
                .req(eff_req[g]),
                .take(take && arb_idx == 6'(g)),
                .wr_byte(reg_wr && hit(reg_addr, `MIPC_CTL_BASE, g)),
                .wr_bit(reg_wr && hit(reg_addr, `MIPC_BIT_BASE, g)),
                .bit_sel(reg_wdata[2:0]),
                .bit_val(reg_wdata[3]),
                .wdata(reg_wdata[7:0]),
                .ctl(ctl[g])
            );
        end
    endgenerate

    mipc_arbiter u_arb (
        .ctl(ctl),
        .valid(arb_valid),
        .idx(arb_idx),
        .lvl(arb_lvl)
    );

    // Most urgent level now in service, or none
    always_comb begin
        isr_top = `MIPC_LVL_NONE;
        for (int i = 7; i >= 0; i--) begin
            if (in_service[i]) begin
                isr_top = 4'(i);
            end
        end
    end

    // NMI outranks everything; the maskable side waits for it
    assign nmi_take = (nmi_in || nmi_held) && !np_flag;
    assign take = arb_valid && !np_flag && !id_flag
        && !nmi_take && {1'b0, arb_lvl} < isr_top;
    assign return_from_irq_m = core_in.return_from_irq && !ep_flag && !np_flag;
    assign return_from_irq_n = core_in.return_from_irq && !ep_flag && np_flag;

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            nmi_held <= 1'b0;
        end else if (nmi_in && np_flag) begin
            nmi_held <= 1'b1;
        end else if (nmi_take) begin
            nmi_held <= 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            status_word <= `MIPC_PSW_RESET;
        end else if (nmi_take) begin
            status_word[`MIPC_NP_BIT] <= 1'b1;
            status_word[`MIPC_ID_BIT] <= 1'b1;
            status_word[`MIPC_EP_BIT] <= 1'b0;
        end else if (take) begin
            status_word[`MIPC_ID_BIT] <= 1'b1;
            status_word[`MIPC_EP_BIT] <= 1'b0;
        end else if (return_from_irq_m) begin
            status_word <= irq_saved_status;
        end else if (return_from_irq_n) begin
            status_word <= nmi_saved_status;
        end else if (core_in.ei) begin
            status_word[`MIPC_ID_BIT] <= 1'b0;
        end else if (core_in.di) begin
            status_word[`MIPC_ID_BIT] <= 1'b1;
        end else if (reg_wr && reg_addr == `MIPC_PSW_ADDR) begin
            status_word <= {24'h000000, reg_wdata[7:0]};
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            irq_saved_pc <= 32'h00000000;
            irq_saved_status <= 32'h00000000;
        end else if (take) begin
            irq_saved_pc <= core_in.pc;
            irq_saved_status <= status_word;
        end else begin
            // Handler saves and restores these around nesting
            if (reg_wr && reg_addr == `MIPC_SPC_ADDR) begin
                irq_saved_pc <= reg_wdata;
            end
            if (reg_wr && reg_addr == `MIPC_SST_ADDR) begin
                irq_saved_status <= reg_wdata;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            nmi_saved_pc <= 32'h00000000;
            nmi_saved_status <= 32'h00000000;
        end else if (nmi_take) begin
            nmi_saved_pc <= core_in.pc;
            nmi_saved_status <= status_word;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            exception_cause_reg <= 32'h00000000;
        end else if (nmi_take) begin
            exception_cause_reg[31:16] <= `MIPC_NMI_CODE;
        end else if (take) begin
            exception_cause_reg[15:0] <= cause_of(arb_idx);
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            in_service <= 8'h00;
        end else if (take) begin
            in_service[arb_lvl] <= 1'b1;
        end else if (return_from_irq_m && isr_top != `MIPC_LVL_NONE) begin
            in_service[isr_top[2:0]] <= 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            vec.valid <= 1'b0;
            vec.nmi <= 1'b0;
            vec.pc <= 32'h00000000;
        end else begin
            vec.valid <= nmi_take || take || return_from_irq_m || return_from_irq_n;
            vec.nmi <= nmi_take;
            if (nmi_take) begin
                vec.pc <= `MIPC_NMI_HANDLER;
            end else if (take) begin
                vec.pc <= {16'h0000, cause_of(arb_idx)};
            end else if (return_from_irq_m) begin
                vec.pc <= irq_saved_pc;
            end else if (return_from_irq_n) begin
                vec.pc <= nmi_saved_pc;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            watchdog_nmi_select <= 1'b0;
            ev_enable <= '0;
        end else if (reg_wr) begin
            if (reg_addr == `MIPC_CFG_ADDR) begin
                watchdog_nmi_select <= reg_wdata[0];
            end
            if (reg_addr == `MIPC_IEN_ADDR) begin
                ev_enable <= reg_wdata[`MIPC_NEV-1:0];
            end
        end
    end

    // Events: maskable acknowledge, NMI acknowledge, NMI held off
    assign ev_set = {nmi_in && np_flag, nmi_take, take};

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            ev_status <= '0;
        end else if (reg_wr && reg_addr == `MIPC_ICLR_ADDR) begin
            ev_status <= (ev_status & ~reg_wdata[`MIPC_NEV-1:0]) | ev_set;
        end else begin
            ev_status <= ev_status | ev_set;
        end
    end

    assign irq = |(ev_status & ev_enable);

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            reg_rdata <= 32'h00000000;
        end else if (!reg_rd) begin
            reg_rdata <= 32'h00000000;
        end else if (reg_addr[7:6] == 2'b00
                     && reg_addr[5:0] < 6'(`MIPC_NSRC)) begin
            reg_rdata <= {24'h000000, ctl[reg_addr[5:0]].flag,
                          ctl[reg_addr[5:0]].mask, 3'h0,
                          ctl[reg_addr[5:0]].pri};
        end else begin
            case (reg_addr)
                `MIPC_PSW_ADDR: reg_rdata <= status_word;
                `MIPC_SPC_ADDR: reg_rdata <= irq_saved_pc;
                `MIPC_SST_ADDR: reg_rdata <= irq_saved_status;
                `MIPC_ECR_ADDR: reg_rdata <= exception_cause_reg;
                `MIPC_IST_ADDR: reg_rdata <= {29'h0, ev_status};
                `MIPC_IEN_ADDR: reg_rdata <= {29'h0, ev_enable};
                `MIPC_CFG_ADDR: reg_rdata <= {31'h0, watchdog_nmi_select};
                `MIPC_ISR_ADDR: reg_rdata <= {24'h0, in_service};
                default: reg_rdata <= 32'h00000000;
            endcase
        end
    end

    nmi_sets_np_a: assert property (@(posedge mclk) disable iff (!rst_n)
        nmi_take |=> np_flag && vec.valid && vec.nmi)
        else $error("NMI acknowledge did not set NP");

    nmi_no_nest_a: assert property (@(posedge mclk) disable iff (!rst_n)
        np_flag && nmi_in |=> !vec.nmi && nmi_held)
        else $error("NMI nested while NP set");

    np_clear_a: assert property (@(posedge mclk) disable iff (!rst_n)
        return_from_irq_n && !nmi_held |=> np_flag == $past(nmi_saved_status[7]))
        else $error("NP not restored on NMI return");

    mask_holds_a: assert property (@(posedge mclk) disable iff (!rst_n)
        take |-> !ctl[arb_idx].mask && ctl[arb_idx].flag)
        else $error("masked source acknowledged");

    id_set_a: assert property (@(posedge mclk) disable iff (!rst_n)
        take |=> id_flag && !take)
        else $error("acknowledge did not disable");

    nest_level_a: assert property (@(posedge mclk) disable iff (!rst_n)
        take |-> {1'b0, arb_lvl} < isr_top)
        else $error("equal or lower level nested");

    wdt_maskable_a: assert property (@(posedge mclk) disable iff (!rst_n)
        src_req[0] && !watchdog_nmi_select |-> !nmi_take || nmi_req
            || nmi_held)
        else $error("watchdog taken as NMI while not selected");

    ack_steps_a: assert property (@(posedge mclk) disable iff (!rst_n)
        take |=> irq_saved_pc == $past(core_in.pc)
            && irq_saved_status == $past(status_word)
            && exception_cause_reg[15:0] == $past(cause_of(arb_idx))
            && !ep_flag
            && vec.pc == {16'h0000, exception_cause_reg[15:0]})
        else $error("acknowledge steps wrong");

    pending_held_a: assert property (@(posedge mclk) disable iff (!rst_n)
        np_flag || id_flag |-> !take)
        else $error("request taken while NP or ID set");

    return_from_irq_restore_a: assert property (@(posedge mclk) disable iff (!rst_n)
        return_from_irq_m && !nmi_take && !take |=> vec.valid
            && vec.pc == $past(irq_saved_pc)
            && status_word == $past(irq_saved_status))
        else $error("return did not restore PC and status");

    ctl_reset_a: assert property (@(posedge mclk)
        !$past(rst_n) && rst_n |-> ctl[1] == 5'h0F && ctl[32] == 5'h0F)
        else $error("control register reset value wrong");

endmodule

/* tb/mipc_partner.sv */
// Purpose: request sources and a core stand-in for the controller
// Assumes: tasks are called just after a rising edge
// Notes: the core PC follows every jump it is handed
`timescale 1ns/100ps
module mipc_partner
    import mipc_pkg::*;
(
    input wire logic mclk, // Clock
    input wire mipc_vec_type vec, // Jump request
    output logic [32:0] src_req, // Source pulses
    output logic nmi_req, // NMI pulse
    output mipc_core_type core_in // Core events
);
    logic [31:0] pc = 32'h00001000;
    logic [2:0] op = 3'h0;
    logic [32:0] jumps[$];
    assign core_in = {pc, op};
    initial begin
        src_req = 33'h0;
        nmi_req = 1'b0;
    end
    always @(posedge mclk) begin
        if (vec.valid === 1'b1) begin
            pc <= vec.pc;
            jumps.push_back({vec.nmi, vec.pc});
        end
    end
    task automatic raise(input logic [32:0] m, input logic n);
        src_req <= m;
        nmi_req <= n;
        @(posedge mclk);
        src_req <= 33'h0;
        nmi_req <= 1'b0;
    endtask
    // One instruction event: 4 return, 2 enable, 1 disable
    task automatic exec(input logic [2:0] k);
        op <= k;
        @(posedge mclk);
        op <= 3'h0;
    endtask
endmodule

/* tb/mipc_irq_ctrl_tb.sv */
// Purpose: self-checking bench of the maskable interrupt controller
// Assumes: partner stands in for sources and core
// Notes: expected jumps come from a level and pending model
`timescale 1ns/100ps
module mipc_irq_ctrl_tb;
    import mipc_pkg::*;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata, status_word, d;
    logic [32:0] src_req;
    logic nmi_req, irq;
    mipc_core_type core_in;
    mipc_vec_type vec;
    int fails = 0, n_checks = 0, seed = 3;
    int lvl[33], msk[33], pend[33], isq[$];
    int st, sst, spc, cpc, keep_pc, keep_st;
    mipc_irq_ctrl i_dut(.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .src_req(src_req), .nmi_req(nmi_req),
        .core_in(core_in), .vec(vec), .status_word(status_word), .irq(irq));
    mipc_partner i_core(.mclk(mclk), .vec(vec), .src_req(src_req),
        .nmi_req(nmi_req), .core_in(core_in));
    initial begin
        forever #50 mclk = ~mclk;
    end
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge mclk);
        fails++;
        stop_test();
    end
    task automatic chk(input string s, input logic [31:0] e, g);
        n_checks++;
        if (g !== e) begin
            $display("unexpected %s exp %h got %h", s, e, g);
            fails++;
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic rdc(input string s, input logic [7:0] a,
                       input logic [31:0] e);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
        chk(s, e, d);
        @(posedge mclk);
    endtask
    task automatic wr_ctl(input int n, input logic [7:0] v);
        wr(n[7:0], {24'h0, v});
        msk[n] = v[6];
        lvl[n] = v[2:0];
    endtask
    function automatic int best();
        int b = -1;
        int lim = 8;
        foreach (isq[j]) begin
            if (isq[j] < lim)
                lim = isq[j];
        end
        for (int i = 0; i < 33; i++) begin
            if (pend[i] && !msk[i] && lvl[i] < lim)
                if (b < 0 || lvl[i] < lvl[b])
                    b = i;
        end
        return b;
    endfunction
    task automatic jump(input logic [32:0] e);
        logic [32:0] g = 33'h0;
        #1;
        for (int i = 0; i < 12 && i_core.jumps.size() == 0; i++)
            #100;
        if (i_core.jumps.size() > 0)
            g = i_core.jumps.pop_front();
        chk("jump_pc", e[31:0], g[31:0]);
        chk("jump_nmi", {31'h0, e[32]}, {31'h0, g[32]});
    endtask
    task automatic no_jump(input int n);
        repeat (n) @(posedge mclk);
        #1 chk("jump_count", 32'h0, 32'(i_core.jumps.size()));
    endtask
    task automatic ack(input logic c);
        int w;
        w = best();
        jump({1'b0, 32'h80 + 32'h10 * w});
        sst = st;
        spc = cpc;
        st = (st | 32'h20) & ~32'h40;
        cpc = 32'h80 + 16 * w;
        pend[w] = 0;
        isq.push_back(lvl[w]);
        chk("status", st, status_word);
        if (c)
            rdc("saved_pc", 8'h84, spc);
        rdc("saved_st", 8'h88, sst);
        rdc("cause", 8'h8C, cpc & 32'hFFFF);
    endtask
    task automatic return_from_irq();
        int k = 0;
        i_core.exec(3'h4);
        foreach (isq[j]) begin
            if (isq[j] < isq[k])
                k = j;
        end
        isq.delete(k);
        // Status is restored at the return edge; a pending request may
        // be taken one edge later, so look before that
        st = sst;
        #1 chk("status", st, status_word);
        jump({1'b0, spc[31:0]});
        cpc = spc;
    endtask
    initial begin
        for (int i = 0; i < 33; i++) begin
            lvl[i] = 7;
            msk[i] = 1;
            pend[i] = 0;
        end
        st = 32'h20;
        cpc = 32'h1000;
        repeat (5) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        chk("status", 32'h20, status_word);
        for (int i = 0; i < 33; i++)
            rdc("ctl", i[7:0], 32'h47);
        rdc("unmapped", 8'hFF, 32'h0);
        for (int i = 1; i < 33; i++) begin
            d = $random(seed);
            wr_ctl(i, {2'b01, d[5:0]});
            rdc("ctl", i[7:0], {26'h1, 3'h0, d[2:0]});
        end
        wr_ctl(3, 8'h42);
        wr(8'h43, 32'h6);
        msk[3] = 0;
        rdc("ctl", 8'h03, 32'h02);
        wr_ctl(5, 8'h01);
        wr_ctl(7, 8'h01);
        wr_ctl(9, 8'h00);
        i_core.raise(33'h828, 1'b0);
        pend[3] = 1;
        pend[5] = 1;
        pend[11] = 1;
        no_jump(6);
        rdc("ctl", 8'h03, 32'h82);
        i_core.exec(3'h2);
        st = st & ~32'h20;
        ack(1'b1);
        rdc("saved_pc", 8'h84, spc);
        keep_pc = spc;
        keep_st = sst;
        no_jump(4);
        i_core.exec(3'h2);
        st = st & ~32'h20;
        i_core.raise(33'h80, 1'b0);
        pend[7] = 1;
        no_jump(6);
        i_core.raise(33'h200, 1'b0);
        pend[9] = 1;
        ack(1'b1);
        return_from_irq();
        no_jump(4);
        i_core.exec(3'h1);
        wr(8'h84, keep_pc);
        wr(8'h88, keep_st);
        spc = keep_pc;
        sst = keep_st;
        return_from_irq();
        ack(1'b0);
        rdc("events", 8'h90, 32'h1);
        chk("irq", 32'h0, {31'h0, irq});
        wr(8'h98, 32'h1);
        chk("irq", 32'h1, {31'h0, irq});
        wr(8'h94, 32'h1);
        rdc("events", 8'h90, 32'h0);
        chk("irq", 32'h0, {31'h0, irq});
        i_core.raise(33'h0, 1'b1);
        jump({1'b1, 32'h10});
        chk("status", (st | 32'hA0) & ~32'h40, status_word);
        i_core.raise(33'h0, 1'b1);
        no_jump(6);
        wr(8'h98, 32'h6);
        chk("irq", 32'h1, {31'h0, irq});
        rdc("events", 8'h90, 32'h6);
        rst_n <= 1'b0;
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        chk("status", 32'h20, status_word);
        rdc("ctl", 8'h00, 32'h47);
        wr(8'h00, 32'h0);
        i_core.exec(3'h2);
        i_core.raise(33'h1, 1'b0);
        jump({1'b0, 32'h80});
        stop_test();
    end
endmodule
